//--- core/ell_top.sv
// Encoder loss detection: quadrature loss, loss counter, stop, sine/cosine check
//
// Behaviour
// RL1: A phase pair is normal at opposite levels and lost when both lines are high or both low.
// RL2: A detected quadrature loss sets the quad loss flag to 1.
// RL3: The loss counter goes up by 1 on each evaluation with loss and down by 1 on each without.
// RL4: The loss counter stops at 0 and never goes below it.
// RL5: With stop-on-loss enabled the motor is stopped once the counter exceeds the threshold.
// RL6: Software should set the threshold to 40 or more when stop-on-loss is used.
// RL7: Software must not rely on quadrature loss detection with single-ended wiring.
// RL8: The sum of squared sine and cosine is compared with a constant and a departure sets its error flag.
// RL9: Software sets the sample divider to 1 at 2 MHz input or more and leaves it at 3 below.
// RL10: Quadrature input is taken up to 2 MHz normally and up to 8 MHz with the fast divider.
// RL11: Above 1.5 MHz a passing four-count error may appear but never accumulates; here each skip loses its counts for good, so errors add up.
// RL12: At 2 MHz or more software should judge the sum-of-squares value itself against a threshold.
// RL13: The spare Hall input reads as a plain digital input.
// RL14: Loss is evaluated and the counter updated once per servo cycle, and stop uses the new count.
`timescale 1ns/1ps
`default_nettype none
`include "ell_defines.svh"

module ell_top (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic servo_tick_i,
   input wire logic quad_a_p_i,
   input wire logic quad_a_n_i,
   input wire logic quad_b_p_i,
   input wire logic quad_b_n_i,
   input wire logic [`ELL_DIV_W-1:0] encoder_sample_divider_i,
   input wire logic stop_on_loss_en_i,
   input wire logic [`ELL_CNT_W-1:0] loss_stop_threshold_i,
   input wire logic quad_loss_clear_i,
   input wire logic sos_error_clear_i,
   input wire logic motor_stop_clear_i,
   input wire logic signed [`ELL_SMP_W-1:0] sine_sample_i,
   input wire logic signed [`ELL_SMP_W-1:0] cosine_sample_i,
   input wire logic [`ELL_SOS_W-1:0] sos_expected_i,
   input wire logic [`ELL_SOS_W-1:0] sos_tolerance_i,
   input wire logic hall_spare_i,
   output logic quad_loss_flag_o,
   output logic [`ELL_CNT_W-1:0] loss_event_counter_o,
   output logic motor_stop_o,
   output logic [`ELL_POS_W-1:0] position_o,
   output logic position_slip_o,
   output logic [`ELL_SOS_W-1:0] sum_squares_value_o,
   output logic sum_squares_error_flag_o,
   output logic hall_spare_o
);

   ell_pkg::ell_state_t st_q;
   ell_pkg::ell_state_t st_d;
   ell_sos_if sos_bus ();

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // A pair is lost when true and complement agree
   function automatic logic ell_pair_lost(input logic p, input logic n);
      return p == n; // RL1
   endfunction : ell_pair_lost

   // Gray-code direction: +1, -1, a separate skip code for a skipped step, or none for a still step
   function automatic logic [1:0] ell_quad_dir(input logic [1:0] prev, input logic [1:0] cur);
      logic [3:0] t;
      t = {prev, cur};
      case (t)
         4'h1, 4'h7, 4'he, 4'h8: return 2'h1;
         4'h2, 4'hb, 4'hd, 4'h4: return 2'h2;
         4'h3, 4'hc, 4'h6, 4'h9: return 2'h3;
         default: return 2'h0;
      endcase
   endfunction : ell_quad_dir

   // ------------------------------------------------------------
   // Derived conditions
   // ------------------------------------------------------------
   logic loss_now;
   logic samp_en;
   logic [1:0] ab_now;
   logic [1:0] dir;

   // Loss on either phase counts as one loss for this cycle
   assign loss_now = ell_pair_lost(quad_a_p_i, quad_a_n_i) | ell_pair_lost(quad_b_p_i, quad_b_n_i); // RL1
   // Divider 1 samples every other clock, 3 every fourth; zero samples every clock
   assign samp_en = st_q.div_cnt == `ELL_DIV_ZERO; // RL10
   assign ab_now = {quad_a_p_i, quad_b_p_i};
   assign dir = ell_quad_dir(st_q.ab_prev, ab_now);

   // ------------------------------------------------------------
   // Sum-of-squares checker
   // ------------------------------------------------------------
   assign sos_bus.tick = servo_tick_i;
   assign sos_bus.sine = sine_sample_i;
   assign sos_bus.cosine = cosine_sample_i;
   assign sos_bus.expected = sos_expected_i;
   assign sos_bus.tolerance = sos_tolerance_i;

   ell_sos_check u_sos (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .sos(sos_bus)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic [`ELL_CNT_W-1:0] cnt_n;
      cnt_n = st_q.loss_cnt;
      st_d = st_q;
      st_d.hall = hall_spare_i; // RL13

      // Sample divider; reloads from the live setting each period
      if (samp_en) begin
         st_d.div_cnt = encoder_sample_divider_i;
      end else begin
         st_d.div_cnt = st_q.div_cnt - `ELL_DIV_ONE;
      end

      // Quadrature decoder; a skipped step is held, not guessed, so each skip leaves its counts out of the position
      st_d.slip = 1'b0;
      if (samp_en) begin
         st_d.ab_prev = ab_now;
         case (st_q.dec)
            ell_pkg::ELL_DEC_IDLE: begin
               st_d.dec = ell_pkg::ELL_DEC_TRACK;
            end
            ell_pkg::ELL_DEC_TRACK, ell_pkg::ELL_DEC_SLIP: begin
               st_d.dec = ell_pkg::ELL_DEC_TRACK;
               if (dir == 2'h1) begin
                  st_d.position = st_q.position + `ELL_POS_STEP; // RL11
               end else if (dir == 2'h2) begin
                  st_d.position = st_q.position - `ELL_POS_STEP; // RL11
               end else if (dir == 2'h3) begin
                  st_d.dec = ell_pkg::ELL_DEC_SLIP; // RL11
                  st_d.slip = 1'b1;
               end
            end
            default: begin
               st_d.dec = ell_pkg::ELL_DEC_IDLE;
            end
         endcase
      end

      // Loss evaluation once per servo cycle
      if (servo_tick_i) begin
         if (loss_now) begin
            if (st_q.loss_cnt != `ELL_CNT_CEIL) begin
               cnt_n = st_q.loss_cnt + `ELL_CNT_STEP; // RL3
            end
         end else if (st_q.loss_cnt != `ELL_CNT_FLOOR) begin
            cnt_n = st_q.loss_cnt - `ELL_CNT_STEP; // RL3 RL4
         end
         st_d.loss_cnt = cnt_n; // RL14
      end

      // Sticky flags: a set in the same cycle as its clear wins
      if (quad_loss_clear_i) begin
         st_d.quad_loss = 1'b0;
      end
      if (servo_tick_i && loss_now) begin
         st_d.quad_loss = 1'b1; // RL2
      end
      if (sos_error_clear_i) begin
         st_d.sos_err = 1'b0;
      end
      if (sos_bus.error_pulse) begin
         st_d.sos_err = 1'b1; // RL8
      end

      // Stop decision on the freshly updated count; latched until released
      if (motor_stop_clear_i) begin
         st_d.stop = 1'b0;
      end
      if (servo_tick_i && stop_on_loss_en_i && cnt_n > loss_stop_threshold_i) begin
         st_d.stop = 1'b1; // RL5 RL14
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         st_q <= '0;
         st_q.dec <= ell_pkg::ELL_DEC_IDLE;
         st_q.div_cnt <= `ELL_DIV_DEFAULT;
         st_q.position <= `ELL_POS_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign quad_loss_flag_o = st_q.quad_loss;
   assign loss_event_counter_o = st_q.loss_cnt;
   assign motor_stop_o = st_q.stop;
   assign position_o = st_q.position;
   assign position_slip_o = st_q.slip;
   assign sum_squares_value_o = sos_bus.sum;
   assign sum_squares_error_flag_o = st_q.sos_err;
   assign hall_spare_o = st_q.hall;

endmodule : ell_top

`default_nettype wire

//--- core/ell_defines.svh
// Constants for the encoder loss detection block
`ifndef ELL_DEFINES_SVH
`define ELL_DEFINES_SVH

// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define ELL_CNT_W 16
`define ELL_POS_W 32
`define ELL_SMP_W 16
`define ELL_SOS_W 32
`define ELL_DIV_W 2

// ------------------------------------------------------------
// Counter limits and steps
// ------------------------------------------------------------
`define ELL_CNT_FLOOR 16'h0000
`define ELL_CNT_CEIL 16'hffff
`define ELL_CNT_STEP 16'h0001
`define ELL_POS_STEP 32'h0000_0001

// ------------------------------------------------------------
// Sample divider: 1 for high-frequency use, 3 is the default
// ------------------------------------------------------------
`define ELL_DIV_FAST 2'h1
`define ELL_DIV_DEFAULT 2'h3
`define ELL_DIV_ZERO 2'h0
`define ELL_DIV_ONE 2'h1

// ------------------------------------------------------------
// Frequency figures in kHz
// ------------------------------------------------------------
`define ELL_CLK_KHZ 10000
`define ELL_FIN_NORMAL_KHZ 2000
`define ELL_FIN_FAST_KHZ 8000
`define ELL_FIN_EXACT_KHZ 1500

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ELL_SOS_RST 32'h0000_0000
`define ELL_POS_RST 32'h0000_0000

`endif

//--- core/ell_pkg.sv
// Types shared by the encoder loss detection modules
`include "ell_defines.svh"

package ell_pkg;

   // ------------------------------------------------------------
   // Quadrature decoder states (one-hot)
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ELL_DEC_IDLE = 3'h1,
      ELL_DEC_TRACK = 3'h2,
      ELL_DEC_SLIP = 3'h4
   } ell_dec_state_t;

   // ------------------------------------------------------------
   // Main block state
   // ------------------------------------------------------------
   typedef struct packed {
      ell_dec_state_t dec;
      logic [`ELL_DIV_W-1:0] div_cnt;
      logic [1:0] ab_prev;
      logic [`ELL_POS_W-1:0] position;
      logic slip;
      logic [`ELL_CNT_W-1:0] loss_cnt;
      logic quad_loss;
      logic sos_err;
      logic stop;
      logic hall;
   } ell_state_t;

   // ------------------------------------------------------------
   // Sum-of-squares checker state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [`ELL_SOS_W-1:0] sum;
      logic err;
   } ell_sos_state_t;

endpackage : ell_pkg

//--- core/ell_sos_if.sv
// Carrier between the loss block and its sum-of-squares checker
`timescale 1ns/1ps
`default_nettype none
`include "ell_defines.svh"

interface ell_sos_if;
   logic tick;
   logic signed [`ELL_SMP_W-1:0] sine;
   logic signed [`ELL_SMP_W-1:0] cosine;
   logic [`ELL_SOS_W-1:0] expected;
   logic [`ELL_SOS_W-1:0] tolerance;
   logic [`ELL_SOS_W-1:0] sum;
   logic error_pulse;

   modport src (output tick, sine, cosine, expected, tolerance, input sum, error_pulse);
   modport chk (input tick, sine, cosine, expected, tolerance, output sum, error_pulse);
endinterface : ell_sos_if

`default_nettype wire

//--- core/ell_sos_check.sv
// Sum-of-squares check for sinusoidal encoder samples
`timescale 1ns/1ps
`default_nettype none
`include "ell_defines.svh"

module ell_sos_check (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   ell_sos_if.chk sos
);

   ell_pkg::ell_sos_state_t st_q;
   ell_pkg::ell_sos_state_t st_d;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Square of a signed sample; never negative, so the cast is safe
   function automatic logic [`ELL_SOS_W-1:0] ell_square(input logic signed [`ELL_SMP_W-1:0] v);
      logic signed [`ELL_SOS_W-1:0] p;
      p = `ELL_SOS_W'(v) * `ELL_SOS_W'(v);
      return unsigned'(p);
   endfunction : ell_square

   // Absolute distance between two unsigned words
   function automatic logic [`ELL_SOS_W-1:0] ell_dist(input logic [`ELL_SOS_W-1:0] a,
                                                     input logic [`ELL_SOS_W-1:0] b);
      return (a >= b) ? (a - b) : (b - a);
   endfunction : ell_dist

   // ------------------------------------------------------------
   // Evaluation once per servo tick
   // ------------------------------------------------------------
   // Both samples are squared in one cycle; 16x16 stays cheap at 10 MHz
   always_comb begin
      logic [`ELL_SOS_W-1:0] s;
      s = ell_square(sos.sine) + ell_square(sos.cosine);
      st_d = st_q;
      st_d.err = 1'b0;
      if (sos.tick) begin
         st_d.sum = s; // RL8
         st_d.err = ell_dist(s, sos.expected) > sos.tolerance; // RL8
      end
   end

   // State register
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sos.sum = st_q.sum;
   assign sos.error_pulse = st_q.err;

endmodule : ell_sos_check

`default_nettype wire

//--- tb/ell_enc_model.sv
// Behavioural differential quadrature encoder
`timescale 1ns/1ps
`default_nettype none

module ell_enc_model (
   input wire logic core_clk_i,
   input wire logic step_i,
   input wire logic [1:0] lost_i,
   input wire logic level_i,
   output logic a_p_o,
   output logic a_n_o,
   output logic b_p_o,
   output logic b_n_o
);
   // ------------------------------------------------------------
   // Phase state and line drive
   // ------------------------------------------------------------
   logic [1:0] ab_q = 2'h0;
   // One Gray step per strobe, always the counting-up direction
   always @(posedge core_clk_i) begin
      if (step_i) begin
         ab_q <= {ab_q[0], ~ab_q[1]};
      end
   end
   // Always wired differentially; an unplugged pair floats to one level
   assign a_p_o = lost_i[1] ? level_i : ab_q[1];
   assign a_n_o = lost_i[1] ? level_i : ~ab_q[1];
   assign b_p_o = lost_i[0] ? level_i : ab_q[0];
   assign b_n_o = lost_i[0] ? level_i : ~ab_q[0];
endmodule : ell_enc_model

`default_nettype wire

//--- tb/ell_top_assertions.sv
// Port checker for the encoder loss block
`timescale 1ns/1ps
`default_nettype none
`include "ell_defines.svh"

module ell_top_assertions (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic servo_tick_i,
   input wire logic quad_a_p_i,
   input wire logic quad_a_n_i,
   input wire logic quad_b_p_i,
   input wire logic quad_b_n_i,
   input wire logic stop_on_loss_en_i,
   input wire logic [`ELL_CNT_W-1:0] loss_stop_threshold_i,
   input wire logic signed [`ELL_SMP_W-1:0] sine_sample_i,
   input wire logic signed [`ELL_SMP_W-1:0] cosine_sample_i,
   input wire logic [`ELL_SOS_W-1:0] sos_expected_i,
   input wire logic [`ELL_SOS_W-1:0] sos_tolerance_i,
   input wire logic hall_spare_i,
   input wire logic quad_loss_flag_o,
   input wire logic [`ELL_CNT_W-1:0] loss_event_counter_o,
   input wire logic motor_stop_o,
   input wire logic [`ELL_SOS_W-1:0] sum_squares_value_o,
   input wire logic sum_squares_error_flag_o,
   input wire logic hall_spare_o
);
   // ------------------------------------------------------------
   // Helper terms
   // ------------------------------------------------------------
   logic lost_w;
   logic [31:0] sq_w;
   logic bad_w;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   // Widened before multiplying so no product is cut short
   assign lost_w = (quad_a_p_i == quad_a_n_i) | (quad_b_p_i == quad_b_n_i);
   assign sq_w = 32'(sine_sample_i) * 32'(sine_sample_i) + 32'(cosine_sample_i) * 32'(cosine_sample_i);
   assign bad_w = ((sq_w > sos_expected_i) ? sq_w - sos_expected_i : sos_expected_i - sq_w) > sos_tolerance_i;
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   cnt_up_a: assert property (
      $past(servo_tick_i) && $past(lost_w) && $past(loss_event_counter_o) != 16'hffff
      |-> loss_event_counter_o == $past(loss_event_counter_o) + 16'h0001) else $error("counter missed a rise");
   cnt_down_a: assert property (
      $past(servo_tick_i) && !$past(lost_w) && $past(loss_event_counter_o) != 16'h0000
      |-> loss_event_counter_o == $past(loss_event_counter_o) - 16'h0001) else $error("counter missed a fall");
   cnt_floor_a: assert property (
      $past(servo_tick_i) && !$past(lost_w) && $past(loss_event_counter_o) == 16'h0000
      |-> loss_event_counter_o == 16'h0000) else $error("counter left zero");
   cnt_hold_a: assert property (
      !$past(servo_tick_i) |-> $stable(loss_event_counter_o)) else $error("counter moved without tick");
   loss_flag_a: assert property (
      $past(servo_tick_i) && $past(lost_w) |-> quad_loss_flag_o) else $error("loss flag not set");
   flag_cause_a: assert property (
      $rose(quad_loss_flag_o) |-> $past(servo_tick_i) && $past(lost_w)) else $error("loss flag without loss");
   stop_set_a: assert property (
      $past(servo_tick_i) && $past(stop_on_loss_en_i) && loss_event_counter_o > $past(loss_stop_threshold_i)
      |-> motor_stop_o) else $error("stop not raised");
   stop_cause_a: assert property (
      $rose(motor_stop_o) |-> $past(stop_on_loss_en_i) && loss_event_counter_o > $past(loss_stop_threshold_i))
      else $error("stop without cause");
   sos_sum_a: assert property (
      $past(servo_tick_i) |-> sum_squares_value_o == $past(sq_w)) else $error("sum of squares wrong");
   sos_err_a: assert property (
      $past(servo_tick_i, 2) && $past(bad_w, 2) |-> sum_squares_error_flag_o) else $error("sum error not set");
   hall_copy_a: assert property (
      $past(reset_n_i) |-> hall_spare_o == $past(hall_spare_i)) else $error("spare input not copied");
   cover property ($rose(motor_stop_o));
   cover property ($rose(sum_squares_error_flag_o));
   cover property (servo_tick_i && !lost_w && loss_event_counter_o == 16'h0000);
endmodule : ell_top_assertions

bind ell_top ell_top_assertions i_chk (.*);

`default_nettype wire

//--- tb/ell_top_test.sv
// Self-checking bench for the encoder loss block
`timescale 1ns/1ps
`default_nettype none
`include "ell_defines.svh"

module ell_top_test;
   // ------------------------------------------------------------
   // Signals, notes and counters
   // ------------------------------------------------------------
   typedef struct {logic [15:0] cnt; logic flag; logic stop; logic [31:0] sum; logic hall;} ell_note_t;
   ell_note_t notes[$];
   ell_note_t got;
   int mismatches = 0;
   int samples_checked = 0;
   integer seed = 32'hde23fb0f;
   int n, s, c, slips = 0;
   logic clk = 0, rst_n = 0, tick = 0, step = 0, lvl = 0, en = 0, hall = 0, flag_e = 0, stop_e = 0, tk = 0, clr = 0;
   logic [1:0] lost = 0, div = 2'h3;
   logic signed [15:0] sine = 0, cosine = 0;
   logic [31:0] expv = 0, tol = 0, sum_e = 0;
   logic [15:0] cnt_e = 0, thr = 16'h0028;
   wire logic a_p, a_n, b_p, b_n, flag, stop, err, hallo, slip;
   wire logic [15:0] cnt;
   wire logic [31:0] pos, sum;

   ell_enc_model i_enc (.core_clk_i(clk), .step_i(step), .lost_i(lost), .level_i(lvl),
      .a_p_o(a_p), .a_n_o(a_n), .b_p_o(b_p), .b_n_o(b_n));
   ell_top i_dut (.core_clk_i(clk), .reset_n_i(rst_n), .servo_tick_i(tick), .quad_a_p_i(a_p),
      .quad_a_n_i(a_n), .quad_b_p_i(b_p), .quad_b_n_i(b_n), .encoder_sample_divider_i(div),
      .stop_on_loss_en_i(en), .loss_stop_threshold_i(thr), .quad_loss_clear_i(clr),
      .sos_error_clear_i(clr), .motor_stop_clear_i(clr), .sine_sample_i(sine), .cosine_sample_i(cosine),
      .sos_expected_i(expv), .sos_tolerance_i(tol), .hall_spare_i(hall), .quad_loss_flag_o(flag),
      .loss_event_counter_o(cnt), .motor_stop_o(stop), .position_o(pos), .position_slip_o(slip),
      .sum_squares_value_o(sum), .sum_squares_error_flag_o(err), .hall_spare_o(hallo));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One servo tick; the expected result is noted as the tick goes out
   task automatic do_tick(input logic [1:0] l, input logic v);
      lost <= l;
      lvl <= v;
      hall <= 1'($random(seed));
      @(posedge clk);
      tick <= 1'b1;
      if (l != 2'b00) cnt_e = (cnt_e == 16'hffff) ? cnt_e : cnt_e + 16'h0001;
      else cnt_e = (cnt_e == 16'h0000) ? cnt_e : cnt_e - 16'h0001;
      flag_e = flag_e | (l != 2'b00);
      stop_e = stop_e | (en && cnt_e > thr);
      notes.push_back(ell_note_t'{cnt_e, flag_e, stop_e, sum_e, hall});
      @(posedge clk);
      tick <= 1'b0;
   endtask : do_tick

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end
      else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize

   // ------------------------------------------------------------
   // Clock, watchdog and result monitor
   // ------------------------------------------------------------
   initial forever #50 clk = ~clk;
   // Whole run is a few hundred cycles; this leaves ample slack
   initial begin
      repeat (3000) @(posedge clk);
      mismatches++;
      summarize();
   end
   // Results land one edge after the tick edge; judged mid-cycle
   always @(posedge clk) tk <= tick;
   // Slip is a one-cycle pulse, so every pulse is counted as it stands
   always @(negedge clk) if (slip === 1'b1) slips++;
   always @(negedge clk) begin
      if (tk && notes.size() > 0) begin
         got = notes.pop_front();
         chk("loss_event_counter", got.cnt, cnt);
         chk("quad_loss_flag", got.flag, flag);
         chk("motor_stop", got.stop, stop);
         chk("sum_squares_value", got.sum, sum);
         chk("hall_spare", got.hall, hallo);
      end
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      div <= 2'h1;
      // First sample after reset only takes the decoder reference
      repeat (6) @(posedge clk);
      repeat (8) begin
         @(posedge clk);
         step <= 1'b1;
         @(posedge clk);
         step <= 1'b0;
         repeat (2) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("position", 32'h0000_0008, pos);
      $display("test position done");
      // Both pairs pulled to one level move both phases at once
      @(posedge clk);
      lost <= 2'b11;
      lvl <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("position_slip", 32'h0000_0001, slips);
      chk("position", 32'h0000_0008, pos);
      $display("test slip done");
      @(posedge clk);
      n = 3 + ($random(seed) & 7);
      repeat (n) do_tick(2'b10, 1'b1);
      repeat (n) do_tick(2'b01, 1'b0);
      repeat (2 * n + 3) do_tick(2'b00, 1'b0);
      $display("test count done");
      en <= 1'b1;
      repeat (41) do_tick(2'b11, 1'b0);
      $display("test stop done");
      s = $random(seed) % 8192;
      c = $random(seed) % 8192;
      sine <= 16'(s);
      cosine <= 16'(c);
      sum_e = 32'(s * s + c * c);
      expv <= sum_e + 32'h0000_0010;
      tol <= 32'h0000_0010;
      do_tick(2'b00, 1'b0);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("sum_squares_error_flag", 1'b0, err);
      @(posedge clk);
      expv <= sum_e + 32'h0000_0011;
      do_tick(2'b00, 1'b0);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("sum_squares_error_flag", 1'b1, err);
      $display("test sum of squares done");
      // Clear strobes drop all three sticky flags
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      @(negedge clk);
      chk("quad_loss_flag", 1'b0, flag);
      chk("motor_stop", 1'b0, stop);
      chk("sum_squares_error_flag", 1'b0, err);
      $display("test clear done");
      summarize();
   end
endmodule : ell_top_test

`default_nettype wire
